// *** hpsh_pkg.sv ***
// package: constants and types for the host port handshake block
package hpsh_pkg;
  // cpu clock period and timing figures in periods
  localparam int CLK_PERIOD_NS   = 10;
  localparam int DATA_LEAD_P     = 2;
  localparam int RST_INVALID_P   = 2;
  localparam int RST_VALID_P     = 4;
  // cycle counts derived from period figures (one period = one cycle)
  localparam int DATA_LEAD_CYC   = (DATA_LEAD_P * CLK_PERIOD_NS
                                    + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_INV_CYC     = (RST_INVALID_P * CLK_PERIOD_NS
                                    + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_VALID_CYC   = (RST_VALID_P * CLK_PERIOD_NS)
                                    / CLK_PERIOD_NS;
  localparam int CNT_W           = 3;
  // access control field codes
  localparam logic [1:0] ACC_CTRL     = 2'h0;
  localparam logic [1:0] ACC_DATA_INC = 2'h1;
  localparam logic [1:0] ACC_ADDR     = 2'h2;
  localparam logic [1:0] ACC_DATA     = 2'h3;
  // configuration strap positions on the data bus
  localparam int STRAP_ENDIAN    = 8;
  localparam int STRAP_BOOT_HI   = 4;
  localparam int STRAP_BOOT_LO   = 3;
  localparam logic [15:0] DATA_RST = 16'h0000;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;
  localparam logic [1:0]  BOOT_RST = 2'h0;

  typedef enum logic [5:0] {
    HPSH_IDLE  = 6'b00_0001,
    HPSH_FETCH = 6'b00_0010,
    HPSH_LEAD  = 6'b00_0100,
    HPSH_HOLD  = 6'b00_1000,
    HPSH_DONE  = 6'b01_0000,
    HPSH_BUSY  = 6'b10_0000
  } hpsh_state_t;
endpackage : hpsh_pkg

// *** hpsh_top.sv ***
// module: device end of the sixteen-bit host port handshake
`timescale 1ns/1ps
module hpsh_top
  import hpsh_pkg::*;
(
  input  wire logic        sys_clk_in,
  input  wire logic        rst_b_in,
  input  wire logic        clk_en_in,
  input  wire logic        port_select_n_in,
  input  wire logic        data_strobe_a_in,
  input  wire logic        data_strobe_b_in,
  input  wire logic        addr_strobe_n_in,
  input  wire logic [1:0]  access_ctrl_sel_in,
  input  wire logic        read_not_write_in,
  input  wire logic        halfword_id_in,
  input  wire logic [15:0] host_data_bus_in,
  input  wire logic        host_irq_req_in,
  input  wire logic        dma_done_in,
  input  wire logic [31:0] dma_rdata_in,
  output logic [15:0]      host_data_bus_out,
  output logic             host_data_bus_oe_n_out,
  output logic             port_not_ready_out,
  output logic             host_irq_out,
  output logic             dma_req_out,
  output logic             dma_write_out,
  output logic [31:0]      dma_wdata_out,
  output logic             big_endian_out,
  output logic [1:0]       boot_mode_out
);

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers: first stage feeds only the second
  logic [23:0] sy1_ff, sy2_ff;
  logic [23:0] pins;
  assign pins = {host_data_bus_in, access_ctrl_sel_in, read_not_write_in,
                 halfword_id_in, addr_strobe_n_in, port_select_n_in,
                 data_strobe_a_in, data_strobe_b_in};
  always_ff @(posedge sys_clk_in) begin
    if (clk_en_in) begin
      sy1_ff <= pins;
      sy2_ff <= sy1_ff;
    end
  end

  logic [15:0] s_data;
  logic [1:0]  s_ctrl;
  logic        s_rnw, s_hw, s_as_n, s_cs_n, s_ds_a, s_ds_b;
  assign {s_data, s_ctrl, s_rnw, s_hw, s_as_n, s_cs_n, s_ds_a, s_ds_b}
    = sy2_ff;

  function automatic logic xfer_n_f(input logic cs_n, input logic a,
                                    input logic b);
    xfer_n_f = ~(a ^ b) | cs_n;
  endfunction : xfer_n_f

  function automatic logic is_data_f(input logic [1:0] c);
    is_data_f = (c == ACC_DATA) || (c == ACC_DATA_INC);
  endfunction : is_data_f

  logic xfer_strobe_n;
  assign xfer_strobe_n = xfer_n_f(s_cs_n, s_ds_a, s_ds_b);

  ////////////////////////////////////////////////////////////////////////
  // edge history and captured selects
  logic        strb_d_ff, nxt_strb_d;
  logic        as_d_ff, nxt_as_d;
  logic        cs_d_ff, nxt_cs_d;
  logic [1:0]  ctrl_ff, nxt_ctrl;
  logic        rnw_ff, nxt_rnw;
  logic        hw_ff, nxt_hw;
  logic        strb_fall, strb_rise, as_fall, sel_edge;
  assign strb_fall = strb_d_ff & ~xfer_strobe_n;
  assign strb_rise = ~strb_d_ff & xfer_strobe_n;
  assign as_fall   = as_d_ff & ~s_as_n;
  // selects latched at address strobe fall, else at strobe fall
  assign sel_edge  = as_fall | (strb_fall & s_as_n);

  always_comb begin
    nxt_strb_d = xfer_strobe_n;
    nxt_as_d   = s_as_n;
    nxt_cs_d   = s_cs_n;
    nxt_ctrl   = ctrl_ff;
    nxt_rnw    = rnw_ff;
    nxt_hw     = hw_ff;
    if (sel_edge) begin
      nxt_ctrl = s_ctrl;
      nxt_rnw  = s_rnw;
      nxt_hw   = s_hw;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      strb_d_ff <= 1'b1;
      as_d_ff   <= 1'b1;
      cs_d_ff   <= 1'b1;
      ctrl_ff   <= ACC_CTRL;
      rnw_ff    <= 1'b1;
      hw_ff     <= 1'b0;
    end else if (clk_en_in) begin
      strb_d_ff <= nxt_strb_d;
      as_d_ff   <= nxt_as_d;
      cs_d_ff   <= nxt_cs_d;
      ctrl_ff   <= nxt_ctrl;
      rnw_ff    <= nxt_rnw;
      hw_ff     <= nxt_hw;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // handshake state machine and data register
  hpsh_state_t      st_ff, nxt_st;
  logic [31:0]      word_ff, nxt_word;
  logic [15:0]      lowh_ff, nxt_lowh;
  logic [CNT_W-1:0] cnt_ff, nxt_cnt;
  logic             busy_ff, nxt_busy;
  logic             rdy_n_ff, nxt_rdy_n;
  logic             oe_n_ff, nxt_oe_n;
  logic [15:0]      dout_ff, nxt_dout;
  logic             req_ff, nxt_req;
  logic             wr_ff, nxt_wr;
  logic [31:0]      wdat_ff, nxt_wdat;
  logic             word_ok_ff, nxt_word_ok;
  logic             acc_data, acc_first, acc_second;

  assign acc_data   = is_data_f(sel_edge ? s_ctrl : ctrl_ff);
  assign acc_first  = ~(sel_edge ? s_hw : hw_ff);
  assign acc_second = ~acc_first;

  always_comb begin
    nxt_st      = st_ff;
    nxt_word    = word_ff;
    nxt_lowh    = lowh_ff;
    nxt_cnt     = cnt_ff;
    nxt_busy    = busy_ff;
    nxt_rdy_n   = rdy_n_ff;
    nxt_oe_n    = oe_n_ff;
    nxt_dout    = dout_ff;
    nxt_req     = 1'b0;
    nxt_wr      = wr_ff;
    nxt_wdat    = wdat_ff;
    nxt_word_ok = word_ok_ff;
    if (dma_done_in) begin
      nxt_busy = 1'b0;
    end
    unique case (st_ff)
      HPSH_IDLE: begin
        // a leftover internal access shows at select fall
        if (cs_d_ff & ~s_cs_n & busy_ff) begin
          nxt_rdy_n = 1'b1;
          nxt_st    = HPSH_BUSY;
        end else if (sel_edge & acc_data) begin
          if ((sel_edge ? s_rnw : rnw_ff) & acc_first & ~word_ok_ff) begin
            nxt_req   = 1'b1;
            nxt_wr    = 1'b0;
            nxt_busy  = 1'b1;
            nxt_rdy_n = 1'b1;
            nxt_st    = HPSH_FETCH;
          end else if (~xfer_strobe_n) begin
            nxt_st = HPSH_HOLD;
          end
        end else if (~xfer_strobe_n & ~strb_d_ff) begin
          nxt_st = HPSH_HOLD;
        end
      end
      HPSH_FETCH: begin
        if (dma_done_in) begin
          nxt_word    = dma_rdata_in;
          nxt_word_ok = 1'b1;
          nxt_cnt     = CNT_W'(DATA_LEAD_CYC);
          nxt_st      = HPSH_LEAD;
        end
      end
      HPSH_LEAD: begin
        // data settles on the bus before ready drops
        // one extra count covers the dout register stage
        if (cnt_ff == '0) begin
          nxt_rdy_n = 1'b0;
          nxt_st    = HPSH_HOLD;
        end
        nxt_cnt = cnt_ff - CNT_W'(1);
      end
      HPSH_HOLD: begin
        if (strb_rise) begin
          nxt_st = HPSH_IDLE;
          if (is_data_f(ctrl_ff)) begin
            if (~rnw_ff & ~hw_ff) begin
              nxt_lowh = s_data;
            end
            // word completes on second halfword only
            if (hw_ff & ~rnw_ff) begin
              nxt_wdat  = {lowh_ff, s_data};
              nxt_wr    = 1'b1;
              nxt_req   = 1'b1;
              nxt_busy  = 1'b1;
              nxt_rdy_n = 1'b1;
              nxt_st    = HPSH_DONE;
            end else if (hw_ff & rnw_ff) begin
              nxt_word_ok = 1'b0;
              if (ctrl_ff == ACC_DATA_INC) begin
                nxt_req   = 1'b1; // prefetch next word
                nxt_wr    = 1'b0;
                nxt_busy  = 1'b1;
                nxt_rdy_n = 1'b1;
                nxt_st    = HPSH_DONE;
              end
            end
          end
        end
      end
      HPSH_DONE: begin
        if (cs_d_ff & ~s_cs_n) begin
          nxt_rdy_n = 1'b1;
        end
        if (~busy_ff | dma_done_in) begin
          if (dma_done_in & ~wr_ff) begin
            nxt_word    = dma_rdata_in;
            nxt_word_ok = 1'b1;
          end
          nxt_rdy_n = 1'b0;
          nxt_st    = HPSH_IDLE;
        end
      end
      HPSH_BUSY: begin
        if (~busy_ff | dma_done_in) begin
          nxt_rdy_n = 1'b0;
          nxt_st    = HPSH_IDLE;
        end
      end
      default: nxt_st = HPSH_IDLE;
    endcase
    // drive only during reads, strobe low
    nxt_oe_n = ~(~xfer_strobe_n & (sel_edge ? s_rnw : rnw_ff));
    nxt_dout = hw_ff ? word_ff[15:0] : word_ff[31:16];
    if (s_cs_n) begin
      nxt_rdy_n = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // reset sequencing: outputs settle before reset release ends
  logic [CNT_W-1:0] rst_cnt_ff, nxt_rst_cnt;
  logic             rst_seen_ff, nxt_rst_seen;
  logic             endian_ff, nxt_endian;
  logic [1:0]       boot_ff, nxt_boot;
  logic             irq_ff, nxt_irq;
  always_comb begin
    nxt_rst_cnt  = rst_cnt_ff;
    nxt_rst_seen = 1'b0;
    nxt_endian   = endian_ff;
    nxt_boot     = boot_ff;
    nxt_irq      = host_irq_req_in & (rst_cnt_ff == '0);
    if (rst_seen_ff) begin
      // first cycle after release: strap capture
      nxt_endian = s_data[STRAP_ENDIAN];
      nxt_boot   = s_data[STRAP_BOOT_HI:STRAP_BOOT_LO];
    end
    if (rst_cnt_ff != '0) begin
      nxt_rst_cnt = rst_cnt_ff - CNT_W'(1);
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      // data bus floats, ready and irq go low after the first edges of reset
      st_ff       <= HPSH_IDLE;
      cnt_ff      <= '0;
      busy_ff     <= 1'b0;
      rdy_n_ff    <= 1'b0;
      oe_n_ff     <= 1'b1;
      dout_ff     <= DATA_RST;
      word_ff     <= WORD_RST;
      lowh_ff     <= DATA_RST;
      req_ff      <= 1'b0;
      wr_ff       <= 1'b0;
      wdat_ff     <= WORD_RST;
      word_ok_ff  <= 1'b0;
      rst_cnt_ff  <= CNT_W'(RST_VALID_CYC - 1);
      rst_seen_ff <= 1'b1;
      irq_ff      <= 1'b0;
    end else if (clk_en_in) begin
      st_ff       <= nxt_st;
      cnt_ff      <= nxt_cnt;
      busy_ff     <= nxt_busy;
      rdy_n_ff    <= nxt_rdy_n;
      oe_n_ff     <= nxt_oe_n;
      dout_ff     <= nxt_dout;
      word_ff     <= nxt_word;
      lowh_ff     <= nxt_lowh;
      req_ff      <= nxt_req;
      wr_ff       <= nxt_wr;
      wdat_ff     <= nxt_wdat;
      word_ok_ff  <= nxt_word_ok;
      rst_cnt_ff  <= nxt_rst_cnt;
      rst_seen_ff <= nxt_rst_seen;
      irq_ff      <= nxt_irq;
    end
  end

  // straps hold their value through reset; caught after release
  always_ff @(posedge sys_clk_in) begin
    if (clk_en_in) begin
      endian_ff <= rst_b_in ? nxt_endian : endian_ff;
      boot_ff   <= rst_b_in ? nxt_boot : boot_ff;
    end
  end

  assign host_data_bus_out      = dout_ff;
  assign host_data_bus_oe_n_out = oe_n_ff;
  assign port_not_ready_out     = rdy_n_ff;
  assign host_irq_out           = irq_ff;
  assign dma_req_out            = req_ff;
  assign dma_write_out          = wr_ff;
  assign dma_wdata_out          = wdat_ff;
  assign big_endian_out         = endian_ff;
  assign boot_mode_out          = boot_ff;

endmodule : hpsh_top

// *** hpsh_top_properties.sv ***
// checker: port-level properties of the host port handshake block
`timescale 1ns/1ps
module hpsh_top_checker (
  input wire logic        sys_clk_in,
  input wire logic        rst_b_in,
  input wire logic        port_select_n_in,
  input wire logic        data_strobe_a_in,
  input wire logic        data_strobe_b_in,
  input wire logic [15:0] host_data_bus_in,
  input wire logic        host_irq_req_in,
  input wire logic        dma_done_in,
  input wire logic [15:0] host_data_bus_out,
  input wire logic        host_data_bus_oe_n_out,
  input wire logic        port_not_ready_out,
  input wire logic        host_irq_out,
  input wire logic        dma_req_out,
  input wire logic        dma_write_out,
  input wire logic        big_endian_out,
  input wire logic [1:0]  boot_mode_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);
  // pin-level strobe, before the design's synchronisers
  wire logic stb_n = ~(data_strobe_a_in ^ data_strobe_b_in) | port_select_n_in;
  ////////////////////////////////////////////////////////////////////////////
  a_cs_gates_ready: assert property (port_select_n_in [*4] |=>
    !port_not_ready_out) else $error("ready not low while deselected");
  a_rst_bus_float: assert property (disable iff (1'b0)
    !rst_b_in [*2] |=> host_data_bus_oe_n_out) else $error("bus driven");
  a_rst_flags_low: assert property (disable iff (1'b0)
    !rst_b_in [*2] |=> !port_not_ready_out && !host_irq_out)
    else $error("flags not quiet in reset");
  a_strap_capture: assert property ($rose(rst_b_in) |-> ##5
    {big_endian_out, boot_mode_out} ==
    $past({host_data_bus_in[8], host_data_bus_in[4:3]}, 5))
    else $error("straps not captured");
  a_oe_after_fall: assert property ($fell(host_data_bus_oe_n_out) |->
    !$past(stb_n, 2)) else $error("bus driven without strobe");
  a_oe_idle_off: assert property (stb_n [*4] |=>
    host_data_bus_oe_n_out) else $error("bus driven after strobe rise");
  a_fetch_holds_ready: assert property (dma_req_out &&
    !dma_write_out |-> port_not_ready_out) else $error("fetch while ready");
  a_write_done_ready: assert property (dma_done_in &&
    dma_write_out |-> ##[1:2] !port_not_ready_out)
    else $error("ready late after write");
  a_data_lead_time: assert property ($fell(port_not_ready_out) &&
    !host_data_bus_oe_n_out |->
    host_data_bus_out == $past(host_data_bus_out, 2) &&
    ($past(dma_done_in, 3) || $past(dma_done_in, 4)))
    else $error("read data lead wrong");
  a_busy_bounded: assert property ($rose(port_not_ready_out) |->
    ##[1:60] !port_not_ready_out) else $error("not ready too long");
  c_read_fetch: cover property (dma_req_out && !dma_write_out);
  c_write_done: cover property (dma_done_in && dma_write_out);
  c_bus_driven: cover property ($fell(host_data_bus_oe_n_out));
endmodule : hpsh_top_checker
bind hpsh_top hpsh_top_checker u_hpsh_top_checker (.*);

// *** hpsh_host_model.sv ***
// partner: external host that runs halfword accesses on the port
`timescale 1ns/1ps
module hpsh_host_model (
  input  wire logic        sys_clk_in,
  input  wire logic        nr_in,
  input  wire logic [15:0] data_in,
  output logic             cs_n_out = 1'b1,
  output logic             stb_a_out = 1'b0,
  output logic             stb_b_out = 1'b0,
  output logic             as_n_out = 1'b1,
  output logic [1:0]       ctrl_out = 2'h0,
  output logic             rnw_out = 1'b1,
  output logic             hw_out = 1'b0,
  output logic [15:0]      drv_out = 16'h0118
);
  logic ph = 1'b0;
  task automatic drive(input logic cs, input logic a, input logic b);
    @(posedge sys_clk_in);
    cs_n_out <= cs;
    stb_a_out <= a;
    stb_b_out <= b;
  endtask : drive
  task automatic access(input logic [1:0] c, input logic r, input logic h,
                        input logic use_as, input logic [15:0] wd,
                        output logic [15:0] rd);
    int n;
    @(posedge sys_clk_in);
    ctrl_out <= c; // selects held to the end
    rnw_out <= r;
    hw_out <= h;
    cs_n_out <= 1'b0;
    // released bus shows a changing pattern, not the last value
    drv_out <= r ? ~drv_out : wd;
    @(posedge sys_clk_in);
    as_n_out <= !use_as;
    @(posedge sys_clk_in);
    ph <= !ph;
    stb_a_out <= ph; // strobes differ: active
    stb_b_out <= !ph;
    @(posedge sys_clk_in);
    as_n_out <= 1'b1; // one pulse per strobe period when use_as is set, none otherwise
    repeat (4) @(posedge sys_clk_in); // minimum low time
    n = 0;
    while (n < 80) begin // wait for ready
      @(negedge sys_clk_in);
      if (nr_in === 1'b0) break;
      n++;
    end
    if (n == 80) tb_top.fail_count++; // ready never came
    rd = data_in;
    drive(1'b0, 1'b0, 1'b0);
    drive(1'b1, 1'b0, 1'b0);
    repeat (4) @(posedge sys_clk_in); // minimum high time
  endtask : access
endmodule : hpsh_host_model

// *** tb_top.sv ***
// testbench: drives the host port with the host model and a memory stub
`timescale 1ns/1ps
module tb_top;
  import hpsh_pkg::*;
  logic        clk = 1'b0, rst_b = 1'b0, irq_req = 1'b0, dma_done = 1'b0;
  logic [31:0] dma_rdata = 32'h0000_0000, wword, wdata;
  logic        cs_n, sa, sb, as_n, rnw, hw, wflag, nr_seen, oe_seen;
  logic        oe_n, nr, irq, req, wr, be;
  logic [1:0]  ctrl, boot;
  logic [15:0] drv, bus, d_out, rd;
  int          fail_count = 0, cmp_count = 0, fetches = 0, dcnt = 0;
  int          dma_delay = 3, f0;
  assign bus = oe_n ? drv : d_out;
  initial forever #5 clk = ~clk;
  hpsh_top u_hpsh_top (.sys_clk_in(clk), .rst_b_in(rst_b),
    .clk_en_in(1'b1), .port_select_n_in(cs_n), .data_strobe_a_in(sa),
    .data_strobe_b_in(sb), .addr_strobe_n_in(as_n),
    .access_ctrl_sel_in(ctrl), .read_not_write_in(rnw),
    .halfword_id_in(hw), .host_data_bus_in(bus), .host_irq_req_in(irq_req),
    .dma_done_in(dma_done), .dma_rdata_in(dma_rdata),
    .host_data_bus_out(d_out), .host_data_bus_oe_n_out(oe_n),
    .port_not_ready_out(nr), .host_irq_out(irq), .dma_req_out(req),
    .dma_write_out(wr), .dma_wdata_out(wdata), .big_endian_out(be),
    .boot_mode_out(boot));
  hpsh_host_model u_hpsh_host_model (.sys_clk_in(clk), .nr_in(nr),
    .data_in(bus), .cs_n_out(cs_n), .stb_a_out(sa), .stb_b_out(sb),
    .as_n_out(as_n), .ctrl_out(ctrl), .rnw_out(rnw), .hw_out(hw),
    .drv_out(drv));
  ////////////////////////////////////////////////////////////////////////////
  // memory stub answers each request after dma_delay cycles
  always @(posedge clk) begin
    dma_done <= 1'b0;
    if (req === 1'b1) begin
      fetches++;
      wword = wdata;
      wflag = wr;
      dcnt = dma_delay;
    end else if (dcnt > 0) begin
      dcnt--;
      if (dcnt == 0) dma_done <= 1'b1;
    end
    if (nr === 1'b1) nr_seen = 1'b1;
    if (oe_n === 1'b0) oe_seen = 1'b1;
  end
  task automatic check(input string what, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : give_verdict
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    repeat (5) @(negedge clk);
    check("oe_n in reset", oe_n, 1);
    check("nr in reset", nr, 0);
    @(posedge clk) rst_b <= 1'b1;
    irq_req <= 1'b1;
    repeat (6) @(negedge clk);
    check("straps", {be, boot}, 3'b111);
    check("irq", irq, 1);
    $display("done reset");
  endtask : t_reset
  task automatic t_write;
    nr_seen = 1'b0;
    u_hpsh_host_model.access(ACC_DATA, 1'b0, 1'b0, 1'b0, 16'h1234, rd);
    u_hpsh_host_model.access(ACC_DATA, 1'b0, 1'b1, 1'b0, 16'h5678, rd);
    check("write word", wword, 32'h1234_5678);
    check("write flag", wflag, 1);
    check("busy seen", nr_seen, 1);
    $display("done write");
  endtask : t_write
  task automatic t_read(input logic [1:0] code, input logic use_as);
    f0 = fetches;
    dma_rdata <= 32'hcafe_0123;
    u_hpsh_host_model.access(code, 1'b1, 1'b0, use_as, 16'h0000, rd);
    check("read hw0", rd, 16'hcafe);
    u_hpsh_host_model.access(code, 1'b1, 1'b1, use_as, 16'h0000, rd);
    check("read hw1", rd, 16'h0123);
    repeat (10) @(posedge clk);
    check("fetches", fetches - f0, (code == ACC_DATA_INC) ? 2 : 1);
    $display("done read %0d", code);
  endtask : t_read
  task automatic t_strobe;
    oe_seen = 1'b0;
    f0 = fetches;
    u_hpsh_host_model.drive(1'b0, 1'b1, 1'b1);
    repeat (8) @(posedge clk);
    u_hpsh_host_model.drive(1'b1, 1'b1, 1'b0);
    repeat (8) @(posedge clk);
    u_hpsh_host_model.drive(1'b1, 1'b0, 1'b0);
    check("strobe idle oe", oe_seen, 0);
    check("strobe idle fetch", fetches - f0, 0);
    $display("done strobe");
  endtask : t_strobe
  task automatic t_ctrl;
    nr_seen = 1'b0;
    f0 = fetches;
    for (int i = 0; i < 4; i++) begin
      u_hpsh_host_model.access(i[1] ? ACC_ADDR : ACC_CTRL, i[0], 1'b0,
                               1'b0, 16'h00a5, rd);
    end
    check("ctrl nr", nr_seen, 0);
    check("ctrl fetch", fetches - f0, 0);
    $display("done ctrl");
  endtask : t_ctrl
  task automatic t_busy;
    dma_delay = 30;
    u_hpsh_host_model.access(ACC_DATA, 1'b0, 1'b0, 1'b0, 16'hbeef, rd);
    u_hpsh_host_model.access(ACC_DATA, 1'b0, 1'b1, 1'b0, 16'h0042, rd);
    fork
      u_hpsh_host_model.access(ACC_CTRL, 1'b0, 1'b0, 1'b0, 16'h0001, rd);
      begin
        repeat (5) @(negedge clk);
        check("pending busy", nr, 1);
      end
    join
    check("late word", wword, 32'hbeef_0042);
    dma_delay = 3;
    $display("done busy");
  endtask : t_busy
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    t_reset;
    t_write;
    t_read(ACC_DATA, 1'b1);
    t_strobe;
    t_read(ACC_DATA_INC, 1'b0);
    t_ctrl;
    t_busy;
    give_verdict;
  end
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    give_verdict;
  end
endmodule : tb_top
